// ===== pkg/pitmr_params.svh
// register offsets, reset values and widths of the interval timer
// assumes inclusion by bare name from the design, the checker and the bench
`ifndef PITMR_PARAMS_SVH
`define PITMR_PARAMS_SVH
`define PITMR_ADDR_W 4
`define PITMR_OFF_COUNT 4'h0
`define PITMR_OFF_PERIOD 4'h1
`define PITMR_OFF_SCALE 4'h2
`define PITMR_OFF_CTRL 4'h3
`define PITMR_OFF_STATUS 4'h4
`define PITMR_OFF_MASK 4'h5
`define PITMR_CTRL_EN_BIT 0
`define PITMR_RST_COUNT 16'h0000
`define PITMR_RST_PERIOD 16'h0000
`define PITMR_RST_SCALE 8'h00
`endif

// ===== pkg/pitmr_pkg.sv
// types shared by the interval timer design
// assumes pitmr_params.svh on the include path
`default_nettype none
package pitmr_pkg;
  typedef logic [15:0] pitmr_word_t;
  typedef logic [7:0] pitmr_scale_t;
endpackage : pitmr_pkg
`default_nettype wire

// ===== rtl/pitmr_top.sv
// prescaled interval timer: 16-bit down-counter, 8-bit prescaler, auto-reload
// assumes a single-cycle register port master on sys_clk, synchronous reset
`default_nettype none
`include "pitmr_params.svh"
module pitmr_top
  import pitmr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`PITMR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // register state and next values
  pitmr_word_t timer_count_value_q;
  pitmr_word_t timer_count_value_d;
  pitmr_word_t timer_reload_period_q;
  pitmr_word_t timer_reload_period_d;
  pitmr_scale_t timer_prescale_divisor_q;
  pitmr_scale_t timer_prescale_divisor_d;
  pitmr_scale_t prescale_cnt_q;
  pitmr_scale_t prescale_cnt_d;
  logic enable_q;
  logic enable_d;
  logic status_q;
  logic status_d;
  logic mask_q;
  logic mask_d;
  logic irq_d;
  pitmr_word_t reg_rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // decoded strobes and timer events
  logic tick;
  logic zero_evt;
  logic wr_count;
  logic wr_period;
  logic wr_scale;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic hit(input logic [`PITMR_ADDR_W-1:0] a, input logic [`PITMR_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic pitmr_word_t pad_bit(input logic b);
    pad_bit = {15'h0000, b};
  endfunction : pad_bit

  function automatic pitmr_word_t pad_scale(input pitmr_scale_t s);
    pad_scale = {8'h00, s};
  endfunction : pad_scale

  // count at one: the next tick reloads the period instead of stepping to zero
  function automatic logic is_last(input pitmr_word_t c);
    is_last = (c == 16'h0001);
  endfunction : is_last

  // zero is also reloaded, so a stalled zero sticks only while the period is zero
  function automatic logic needs_reload(input pitmr_word_t c);
    needs_reload = is_last(c) || (c == 16'h0000);
  endfunction : needs_reload

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_count = reg_wr && hit(reg_addr, `PITMR_OFF_COUNT);
  assign wr_period = reg_wr && hit(reg_addr, `PITMR_OFF_PERIOD);
  assign wr_scale = reg_wr && hit(reg_addr, `PITMR_OFF_SCALE);
  assign wr_ctrl = reg_wr && hit(reg_addr, `PITMR_OFF_CTRL);
  assign wr_mask = reg_wr && hit(reg_addr, `PITMR_OFF_MASK);
  assign rd_status = reg_rd && hit(reg_addr, `PITMR_OFF_STATUS);

  // tick once every n+1 cycles: divisor 0 means every cycle
  assign tick = enable_q && (prescale_cnt_q == 8'h00);
  // a count write overrides the tick of that cycle
  assign zero_evt = tick && !wr_count && is_last(timer_count_value_q);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler
  always_comb begin
    prescale_cnt_d = prescale_cnt_q - 8'h01;
    if (wr_scale) begin
      prescale_cnt_d = reg_wdata[7:0];
    end else if (!enable_q || tick) begin
      prescale_cnt_d = timer_prescale_divisor_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale_cnt_q <= `PITMR_RST_SCALE;
    end else begin
      prescale_cnt_q <= prescale_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // down-counter with auto-reload
  always_comb begin
    timer_count_value_d = timer_count_value_q;
    if (wr_count) begin
      timer_count_value_d = reg_wdata;
    end else if (tick) begin
      if (needs_reload(timer_count_value_q)) begin
        timer_count_value_d = timer_reload_period_q;
      end else begin
        timer_count_value_d = timer_count_value_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_count_value_q <= `PITMR_RST_COUNT;
    end else begin
      timer_count_value_q <= timer_count_value_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period register
  always_comb begin
    timer_reload_period_d = timer_reload_period_q;
    if (wr_period) begin
      timer_reload_period_d = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_reload_period_q <= `PITMR_RST_PERIOD;
    end else begin
      timer_reload_period_q <= timer_reload_period_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescale divisor register
  always_comb begin
    timer_prescale_divisor_d = timer_prescale_divisor_q;
    if (wr_scale) begin
      timer_prescale_divisor_d = reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_prescale_divisor_q <= `PITMR_RST_SCALE;
    end else begin
      timer_prescale_divisor_q <= timer_prescale_divisor_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control: run enable
  always_comb begin
    enable_d = enable_q;
    if (wr_ctrl) begin
      enable_d = reg_wdata[`PITMR_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event; a new event beats the read-clear
  always_comb begin
    status_d = status_q;
    if (zero_evt) begin
      status_d = 1'b1;
    end else if (rd_status) begin
      status_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= 1'b0;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level interrupt, registered so the pin comes from a flop
  always_comb begin
    irq_d = status_d && mask_d;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: valid one cycle after the strobe, zero otherwise
  always_comb begin
    reg_rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `PITMR_OFF_COUNT: reg_rdata_d = timer_count_value_q;
        `PITMR_OFF_PERIOD: reg_rdata_d = timer_reload_period_q;
        `PITMR_OFF_SCALE: reg_rdata_d = pad_scale(timer_prescale_divisor_q);
        `PITMR_OFF_CTRL: reg_rdata_d = pad_bit(enable_q);
        `PITMR_OFF_STATUS: reg_rdata_d = pad_bit(status_q);
        `PITMR_OFF_MASK: reg_rdata_d = pad_bit(mask_q);
        default: reg_rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unused write data bits above the widest field are ignored by design;
  // unmapped indices read zero and swallow writes
endmodule : pitmr_top
`default_nettype wire

// ===== tb/pitmr_top_chk.sv
// port checker for the interval timer
// assumes binding to pitmr_top
`default_nettype none
`include "pitmr_params.svh"
module pitmr_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic clr;
  assign clr = (reg_rd && reg_addr == `PITMR_OFF_STATUS) || (reg_wr && reg_addr == `PITMR_OFF_MASK);
  a_irq_holds: assert property (irq && !clr ##1 !clr |=> irq) else $error("irq lost");
  a_mask_gates: assert property (reg_wr && reg_addr == `PITMR_OFF_MASK && !reg_wdata[0] ##1 !clr |=> !irq)
    else $error("irq unmasked");
  a_scale_width: assert property (reg_rd && reg_addr == `PITMR_OFF_SCALE |=> reg_rdata[15:8] == 8'h00)
    else $error("wide scale");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray data");
endmodule : pitmr_chk
`default_nettype wire

// ===== tb/pitmr_top_bench.sv
// register-level bench for the interval timer
// assumes pitmr_top and pitmr_chk compiled first
`default_nettype none
`include "pitmr_params.svh"
module pitmr_top_bench;
  import pitmr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq;
  logic [3:0] reg_addr = 0;
  pitmr_word_t reg_wdata = 0, reg_rdata;
  int fails = 0, checked = 0, cyc = 0;
  pitmr_top uut (.*);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) begin
    fails++;
    results();
  end
  task results();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task chk(input pitmr_word_t got, input pitmr_word_t lo, input pitmr_word_t hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task wr(input logic [3:0] a, input pitmr_word_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input pitmr_word_t lo, input pitmr_word_t hi);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, lo, hi);
  endtask : rd
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`PITMR_OFF_COUNT, 0, 0);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, 0, 0);
    $display("reset test done");
    wr(`PITMR_OFF_SCALE, 16'h0104);
    rd(`PITMR_OFF_SCALE, 4, 4);
    wr(`PITMR_OFF_COUNT, 16'h0100);
    wr(`PITMR_OFF_CTRL, 1);
    repeat (50) @(posedge sys_clk);
    wr(`PITMR_OFF_CTRL, 0);
    rd(`PITMR_OFF_COUNT, 16'h00F4, 16'h00F6);
    $display("rate test done");
    wr(`PITMR_OFF_SCALE, 0);
    wr(`PITMR_OFF_PERIOD, 16'h0040);
    wr(`PITMR_OFF_COUNT, 3);
    wr(`PITMR_OFF_MASK, 1);
    wr(`PITMR_OFF_CTRL, 1);
    repeat (8) @(posedge sys_clk);
    wr(`PITMR_OFF_CTRL, 0);
    rd(`PITMR_OFF_COUNT, 16'h0036, 16'h003E);
    chk({15'h0000, irq}, 1, 1);
    rd(`PITMR_OFF_STATUS, 1, 1);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 0, 0);
    wr(`PITMR_OFF_MASK, 0);
    $display("reload test done");
    results();
  end
endmodule : pitmr_top_bench
bind pitmr_top pitmr_chk chk (.*);
`default_nettype wire
